// ===== logic/rtdc_pkg.sv
package rtdc_pkg;
  localparam logic [2:0] ADDR_SETUP = 3'h0;
  localparam logic [2:0] ADDR_RES_HI = 3'h1;
  localparam logic [2:0] ADDR_RES_LO = 3'h2;
  localparam logic [2:0] ADDR_UP_HI = 3'h3;
  localparam logic [2:0] ADDR_UP_LO = 3'h4;
  localparam logic [2:0] ADDR_LO_HI = 3'h5;
  localparam logic [2:0] ADDR_LO_LO = 3'h6;
  localparam logic [2:0] ADDR_FAULT = 3'h7;
  localparam int WRITE_BIT = 7;
  localparam logic [7:0] RST_SETUP = 8'h00;
  localparam logic [7:0] RST_UP = 8'hff;
  localparam logic [7:0] RST_LO = 8'h00;
  localparam int B_EXCITE = 7;
  localparam int B_CONT = 6;
  localparam int B_SINGLE = 5;
  localparam int B_THREE = 4;
  localparam int B_CYC_HI = 3;
  localparam int B_CYC_LO = 2;
  localparam int B_CLEAR = 1;
  localparam int B_NOTCH = 0;
  localparam int F_HIGH = 7;
  localparam int F_LOW = 6;
  localparam int F_REF_HI = 5;
  localparam int F_REF_OPEN = 4;
  localparam int F_RET_OPEN = 3;
  localparam int F_PINV = 2;
  localparam int CLK_MHZ = 125;
  localparam int CONV60_US = 52000;
  localparam int CONV50_US = 62500;
  localparam int SETTLE_US = 100;
  localparam int CONV60_CYC = CONV60_US * CLK_MHZ;
  localparam int CONV50_CYC = CONV50_US * CLK_MHZ;
  localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
  localparam int CHECK_CYC = 16;
  typedef struct packed {
    logic valid;
    logic write;
    logic [2:0] addr;
    logic [7:0] data;
  } rtdc_wr_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CONV = 3'b001,
    ST_SETTLE = 3'b010,
    ST_CHECK = 3'b011,
    ST_OPEN = 3'b100,
    ST_HOLD = 3'b101
  } rtdc_state_t;
endpackage

// ===== logic/rtdc_serial.sv
`timescale 1ns/1ns
`default_nettype none
// Serial side, on the host clock; chip select low frames a transfer
module rtdc_serial (
  // Reset of the byte hand-over
  input wire logic rst,
  // Link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  output logic sdo,
  // Read data supplied by register side
  input wire logic [63:0] rd_bytes,
  // Completed byte toward register side
  output var rtdc_pkg::rtdc_wr_t wr,
  output logic wr_toggle
);
  logic [2:0] bit_cnt;
  logic [6:0] shift;
  logic have_addr;
  logic is_write;
  logic [7:0] tx;
  logic [2:0] next_addr;
  logic [7:0] next_byte;

  assign next_byte = {shift, sdi};

  // MSB first in and out
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt <= 3'h0;
      shift <= 7'h00;
      have_addr <= 1'b0;
      is_write <= 1'b0;
      next_addr <= 3'h0;
    end else begin
      bit_cnt <= bit_cnt + 3'h1;
      shift <= next_byte[6:0];
      if (bit_cnt == 3'h7) begin
        if (!have_addr) begin
          have_addr <= 1'b1;
          is_write <= next_byte[rtdc_pkg::WRITE_BIT];
          next_addr <= next_byte[2:0];
        end else begin
          next_addr <= next_addr + 3'h1;
        end
      end
    end
  end

  // Hand-over kept across frames; a closing select loses no byte
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      wr <= '0;
      wr_toggle <= 1'b0;
    end else if (bit_cnt == 3'h7 && have_addr) begin
      wr.valid <= 1'b1;
      wr.write <= is_write;
      wr.addr <= next_addr;
      wr.data <= next_byte;
      wr_toggle <= ~wr_toggle;
    end
  end

  // Output shifts on falling edge, byte loaded at its start
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      tx <= 8'h00;
    end else if (bit_cnt == 3'h0 && have_addr) begin
      tx <= {rd_bytes[next_addr*8 +: 7], 1'b0};
    end else begin
      tx <= {tx[6:0], 1'b0};
    end
  end

  always_comb begin
    if (bit_cnt == 3'h0 && have_addr) begin
      sdo = rd_bytes[next_addr*8 + 7];
    end else begin
      sdo = tx[7];
    end
  end
endmodule
`default_nettype wire

// ===== logic/rtdc_core.sv
`timescale 1ns/1ns
`default_nettype none
module rtdc_core (
  // System
  input wire logic CLOCK,
  input wire logic RST,
  // Serial link
  input wire logic SCLK,
  input wire logic CS_N,
  input wire logic SDI,
  output logic SDO,
  // Converter front end
  input wire logic [15:0] ADC_CODE,
  input wire logic ADC_NEGATIVE,
  input wire logic ADC_OVERRANGE,
  input wire logic PIN_VOLT_FAULT,
  input wire logic REF_ABOVE_085,
  input wire logic REF_BELOW_085,
  input wire logic RET_BELOW_085,
  // Controls and status
  output logic EXCITATION_ON,
  output logic RETURN_SWITCH_OPEN,
  output logic THREE_WIRE,
  output logic RESULT_AVAILABLE_N
);
  logic [7:0] setup;
  logic [7:0] res_hi;
  logic [7:0] res_lo;
  logic [7:0] up_hi;
  logic [7:0] up_lo;
  logic [7:0] lo_hi;
  logic [7:0] lo_lo;
  logic [7:0] fault;
  logic [63:0] rd_bytes;
  rtdc_pkg::rtdc_wr_t wr;
  logic wr_toggle;
  logic sdo_link;
  logic [2:0] tog_sync;
  logic [2:0] cs_sync;
  logic link_rst;
  logic cs_prev;
  logic [3:0] in_sync1;
  logic [3:0] in_sync2;
  logic pin_fault;
  logic ref_hi_s;
  logic ref_lo_s;
  logic ret_lo_s;
  logic wr_event;
  logic cs_rise;
  logic single_pend;
  logic [1:0] cyc_req;
  logic manual_one;
  logic [23:0] cnt;
  logic [14:0] new_code;
  logic res_read;
  logic conv_done;
  rtdc_pkg::rtdc_state_t state;
  logic ignore_both;

  assign rd_bytes = {fault, lo_lo, lo_hi, up_lo, up_hi, res_lo, res_hi,
    setup};

  rtdc_serial u_serial (
    .rst(link_rst),
    .sclk(SCLK),
    .cs_n(CS_N),
    .sdi(SDI),
    .sdo(sdo_link),
    .rd_bytes(rd_bytes),
    .wr(wr),
    .wr_toggle(wr_toggle)
  );

  // Data output straight from a flip-flop; tracks link data
  always_ff @(negedge SCLK) begin
    SDO <= sdo_link;
  end

  // Registered reset gives the link side a clean edge, even at start-up
  always_ff @(posedge CLOCK) begin
    link_rst <= RST;
  end

  // Byte event crossing: toggle synchronised, struct stable by then
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      tog_sync <= 3'h0;
      cs_sync <= 3'b111;
      cs_prev <= 1'b1;
      in_sync1 <= 4'h0;
      in_sync2 <= 4'h0;
    end else begin
      tog_sync <= {tog_sync[1:0], wr_toggle};
      cs_sync <= {cs_sync[1:0], CS_N};
      cs_prev <= cs_sync[2];
      in_sync1 <= {PIN_VOLT_FAULT, REF_ABOVE_085, REF_BELOW_085,
        RET_BELOW_085};
      in_sync2 <= in_sync1;
    end
  end

  assign wr_event = tog_sync[2] ^ tog_sync[1];
  // Extra stage: rise lands after the last byte's event
  assign cs_rise = cs_sync[2] & ~cs_prev;
  assign {pin_fault, ref_hi_s, ref_lo_s, ret_lo_s} = in_sync2;
  assign ignore_both = wr.data[rtdc_pkg::B_SINGLE] &
    (wr.data[rtdc_pkg::B_CYC_HI] | wr.data[rtdc_pkg::B_CYC_LO]);

  // Setup register and pending requests
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      setup <= rtdc_pkg::RST_SETUP;
      single_pend <= 1'b0;
      cyc_req <= 2'b00;
    end else begin
      if (wr_event && wr.write && wr.addr == rtdc_pkg::ADDR_SETUP) begin
        setup <= wr.data;
        setup[rtdc_pkg::B_CLEAR] <= 1'b0;
        if (ignore_both) begin
          setup[rtdc_pkg::B_SINGLE] <= 1'b0;
          setup[rtdc_pkg::B_CYC_HI:rtdc_pkg::B_CYC_LO] <=
            setup[rtdc_pkg::B_CYC_HI:rtdc_pkg::B_CYC_LO];
        end else begin
          single_pend <= wr.data[rtdc_pkg::B_SINGLE] &
            ~wr.data[rtdc_pkg::B_CONT];
          cyc_req <= wr.data[rtdc_pkg::B_CYC_HI:rtdc_pkg::B_CYC_LO];
        end
      end else if (cs_rise) begin
        single_pend <= 1'b0;
        cyc_req <= 2'b00;
      end
      if (cs_rise && single_pend) begin
        setup[rtdc_pkg::B_SINGLE] <= 1'b0;
      end
      if (conv_done) begin
        setup[rtdc_pkg::B_CYC_HI:rtdc_pkg::B_CYC_LO] <= 2'b00;
      end
    end
  end

  // Limit registers, writable only at their write addresses
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      up_hi <= rtdc_pkg::RST_UP;
      up_lo <= rtdc_pkg::RST_UP;
      lo_hi <= rtdc_pkg::RST_LO;
      lo_lo <= rtdc_pkg::RST_LO;
    end else if (wr_event && wr.write) begin
      case (wr.addr)
        rtdc_pkg::ADDR_UP_HI: up_hi <= wr.data;
        rtdc_pkg::ADDR_UP_LO: up_lo <= wr.data;
        rtdc_pkg::ADDR_LO_HI: lo_hi <= wr.data;
        rtdc_pkg::ADDR_LO_LO: lo_lo <= wr.data;
        default: up_hi <= up_hi;
      endcase
    end
  end

  // Clamp front end code
  always_comb begin
    if (ADC_NEGATIVE) begin
      new_code = 15'h0000;
    end else if (ADC_OVERRANGE || ADC_CODE[15]) begin
      new_code = 15'h7fff;
    end else begin
      new_code = ADC_CODE[14:0];
    end
  end

  // Conversion and fault cycle sequencer
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      state <= rtdc_pkg::ST_IDLE;
      cnt <= 24'h0;
      conv_done <= 1'b0;
      manual_one <= 1'b0;
      RETURN_SWITCH_OPEN <= 1'b0;
    end else begin
      conv_done <= 1'b0;
      case (state)
        rtdc_pkg::ST_IDLE: begin
          if (cs_rise && cyc_req != 2'b00 && !manual_one) begin
            state <= (cyc_req == 2'b10) ? rtdc_pkg::ST_CHECK :
              rtdc_pkg::ST_SETTLE;
            manual_one <= (cyc_req == 2'b10);
            // Manual step waits on the host, so no settling delay
            cnt <= (cyc_req == 2'b10) ? 24'(rtdc_pkg::CHECK_CYC) :
              24'(rtdc_pkg::SETTLE_CYC);
          end else if (cs_rise && cyc_req == 2'b11 && manual_one) begin
            RETURN_SWITCH_OPEN <= 1'b1;
            state <= rtdc_pkg::ST_OPEN;
            cnt <= 24'(rtdc_pkg::CHECK_CYC);
          end else if (!pin_fault && ((cs_rise && single_pend) ||
              setup[rtdc_pkg::B_CONT])) begin
            state <= rtdc_pkg::ST_CONV;
            cnt <= setup[rtdc_pkg::B_NOTCH] ?
              24'(rtdc_pkg::CONV50_CYC) : 24'(rtdc_pkg::CONV60_CYC);
          end
        end
        rtdc_pkg::ST_CONV: begin
          if (cnt == 24'h1) begin
            state <= rtdc_pkg::ST_IDLE;
          end
          cnt <= cnt - 24'h1;
        end
        rtdc_pkg::ST_SETTLE: begin
          if (cnt == 24'h1) begin
            state <= rtdc_pkg::ST_CHECK;
            cnt <= 24'(rtdc_pkg::CHECK_CYC);
          end else begin
            cnt <= cnt - 24'h1;
          end
        end
        rtdc_pkg::ST_CHECK: begin
          if (cnt == 24'h1) begin
            if (manual_one) begin
              RETURN_SWITCH_OPEN <= 1'b1;
              state <= rtdc_pkg::ST_IDLE;
            end else begin
              RETURN_SWITCH_OPEN <= 1'b1;
              state <= rtdc_pkg::ST_OPEN;
              cnt <= 24'(rtdc_pkg::SETTLE_CYC);
            end
          end else begin
            cnt <= cnt - 24'h1;
          end
        end
        rtdc_pkg::ST_OPEN: begin
          if (cnt == 24'h1) begin
            RETURN_SWITCH_OPEN <= 1'b0;
            manual_one <= 1'b0;
            conv_done <= 1'b1;
            state <= rtdc_pkg::ST_IDLE;
          end else begin
            cnt <= cnt - 24'h1;
          end
        end
        default: state <= rtdc_pkg::ST_IDLE;
      endcase
    end
  end

  assign res_read = wr_event && !wr.write &&
    (wr.addr == rtdc_pkg::ADDR_RES_HI || wr.addr == rtdc_pkg::ADDR_RES_LO);

  // Result pair, fault flags and result available
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      res_hi <= 8'h00;
      res_lo <= 8'h00;
      fault <= 8'h00;
      RESULT_AVAILABLE_N <= 1'b1;
    end else begin
      if (wr_event && wr.write && wr.addr == rtdc_pkg::ADDR_SETUP &&
          wr.data[rtdc_pkg::B_CLEAR] && !wr.data[rtdc_pkg::B_SINGLE] &&
          !wr.data[rtdc_pkg::B_CYC_HI] && !wr.data[rtdc_pkg::B_CYC_LO]) begin
        fault[7:2] <= 6'h00;
      end
      if (pin_fault) begin
        fault[rtdc_pkg::F_PINV] <= 1'b1;
      end
      if (state == rtdc_pkg::ST_CHECK && cnt == 24'h1) begin
        if (ref_hi_s) fault[rtdc_pkg::F_REF_HI] <= 1'b1;
      end
      if (state == rtdc_pkg::ST_OPEN && cnt == 24'h1) begin
        if (ref_lo_s) fault[rtdc_pkg::F_REF_OPEN] <= 1'b1;
        if (ret_lo_s) fault[rtdc_pkg::F_RET_OPEN] <= 1'b1;
      end
      if (res_read) begin
        RESULT_AVAILABLE_N <= 1'b1;
      end
      if (state == rtdc_pkg::ST_CONV && cnt == 24'h1 && !pin_fault) begin
        res_hi <= new_code[14:7];
        res_lo <= {new_code[6:0], (|fault[7:2]) |
          (new_code >= {up_hi, up_lo[7:1]}) |
          (new_code <= {lo_hi, lo_lo[7:1]})};
        if (new_code >= {up_hi, up_lo[7:1]}) begin
          fault[rtdc_pkg::F_HIGH] <= 1'b1;
        end
        if (new_code <= {lo_hi, lo_lo[7:1]}) begin
          fault[rtdc_pkg::F_LOW] <= 1'b1;
        end
        RESULT_AVAILABLE_N <= 1'b0;
      end else begin
        res_lo[0] <= |fault[7:2];
      end
    end
  end

  // Excitation and wiring outputs
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      EXCITATION_ON <= 1'b0;
      THREE_WIRE <= 1'b0;
    end else begin
      EXCITATION_ON <= setup[rtdc_pkg::B_EXCITE] | setup[rtdc_pkg::B_CONT];
      THREE_WIRE <= setup[rtdc_pkg::B_THREE];
    end
  end
endmodule
`default_nettype wire

// ===== test/rtdc_props.sv
`timescale 1ns/1ns
`default_nettype none
module rtdc_props (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // Link and front end
  input wire logic CS_N,
  input wire logic PIN_VOLT_FAULT,
  // Controls and status
  input wire logic EXCITATION_ON,
  input wire logic RETURN_SWITCH_OPEN,
  input wire logic THREE_WIRE,
  input wire logic RESULT_AVAILABLE_N
);
  logic [7:0] idle;
  logic [16:0] up;
  // Cycles since chip select was last low
  always_ff @(posedge CLOCK) begin
    if (RST || !CS_N) begin
      idle <= 8'h00;
    end else if (idle != 8'hff) begin
      idle <= idle + 8'h01;
    end
  end
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      up <= 17'h00000;
    end else if (up != 17'h1ffff) begin
      up <= up + 17'h00001;
    end
  end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  sequence s_quiet;
    idle >= 8'h10;
  endsequence
  sequence s_pin_held;
    PIN_VOLT_FAULT [*6];
  endsequence
  property p_reset_out;
    $fell(RST) |-> !EXCITATION_ON && !RETURN_SWITCH_OPEN && RESULT_AVAILABLE_N;
  endproperty
  property p_no_early;
    (up < 17'h186a0) |-> RESULT_AVAILABLE_N;
  endproperty
  property p_bias_quiet;
    s_quiet |=> $stable(EXCITATION_ON);
  endproperty
  property p_wire_quiet;
    s_quiet |=> $stable(THREE_WIRE);
  endproperty
  property p_sw_open;
    $rose(RETURN_SWITCH_OPEN) |-> int'(idle) >= rtdc_pkg::CHECK_CYC;
  endproperty
  property p_sw_close;
    $fell(RETURN_SWITCH_OPEN) |-> int'(idle) >= rtdc_pkg::CHECK_CYC;
  endproperty
  property p_rdy_read;
    $rose(RESULT_AVAILABLE_N) |-> idle < 8'h10;
  endproperty
  property p_pin_hold;
    s_pin_held |-> !$fell(RESULT_AVAILABLE_N);
  endproperty
  a_reset_out: assert property (p_reset_out)
    else $error("outputs not at reset level");
  a_no_early: assert property (p_no_early)
    else $error("result ready too soon");
  a_bias_quiet: assert property (p_bias_quiet)
    else $error("excitation moved while link idle");
  a_wire_quiet: assert property (p_wire_quiet)
    else $error("wiring mode moved while link idle");
  a_sw_open: assert property (p_sw_open)
    else $error("switch opened before closed check");
  a_sw_close: assert property (p_sw_close)
    else $error("switch closed before open check");
  a_rdy_read: assert property (p_rdy_read)
    else $error("ready cleared without a read");
  a_pin_hold: assert property (p_pin_hold)
    else $error("result loaded during pin fault");
endmodule
bind rtdc_core rtdc_props u_props (
  .CLOCK(CLOCK), .RST(RST), .CS_N(CS_N), .PIN_VOLT_FAULT(PIN_VOLT_FAULT),
  .EXCITATION_ON(EXCITATION_ON), .RETURN_SWITCH_OPEN(RETURN_SWITCH_OPEN),
  .THREE_WIRE(THREE_WIRE), .RESULT_AVAILABLE_N(RESULT_AVAILABLE_N)
);
`default_nettype wire

// ===== test/rtdc_host.sv
`timescale 1ns/1ns
`default_nettype none
module rtdc_host (
  // Link
  output logic sclk,
  output logic cs_n,
  output logic sdi,
  input wire logic sdo,
  // Received read byte
  output logic [7:0] rx,
  output logic rx_tgl
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
    rx = 8'h00;
    rx_tgl = 1'b0;
  end
  task automatic frame_open();
    #5 cs_n = 1'b0;
    #3;
  endtask
  task automatic frame_close();
    #3 cs_n = 1'b1;
    #20;
  endtask
  task automatic xbyte(input logic [7:0] tx, input logic keep);
    logic [7:0] r;
    for (int i = 7; i >= 0; i--) begin
      sdi = tx[i];
      #3 sclk = 1'b1;
      r[i] = sdo;
      #3 sclk = 1'b0;
    end
    // Released line shows the inverse
    sdi = ~sdi;
    if (keep) begin
      rx = r;
      rx_tgl = ~rx_tgl;
    end
  endtask
endmodule
`default_nettype wire

// ===== test/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic sclk, cs_n, sdi, sdo, rx_tgl;
  logic [7:0] rx;
  logic [15:0] adc_code = 16'h0000;
  logic adc_neg = 1'b0, adc_ovr = 1'b0, pin_f = 1'b0;
  logic ref_hi = 1'b0, ref_lo = 1'b0, ret_lo = 1'b0;
  logic exc, sw, three, rdy_n;
  logic [31:0] lfsr = 32'h91bf;
  logic [31:0] alfsr = 32'h91bf;
  logic [7:0] exp_q[$];
  string name_q[$];
  int fails = 0;
  int samples_checked = 0;
  always #4 clock = ~clock;
  rtdc_core dut_u (
    .CLOCK(clock), .RST(rst), .SCLK(sclk), .CS_N(cs_n), .SDI(sdi),
    .SDO(sdo), .ADC_CODE(adc_code), .ADC_NEGATIVE(adc_neg),
    .ADC_OVERRANGE(adc_ovr), .PIN_VOLT_FAULT(pin_f),
    .REF_ABOVE_085(ref_hi), .REF_BELOW_085(ref_lo),
    .RET_BELOW_085(ret_lo), .EXCITATION_ON(exc),
    .RETURN_SWITCH_OPEN(sw), .THREE_WIRE(three),
    .RESULT_AVAILABLE_N(rdy_n)
  );
  rtdc_host host_u (
    .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .rx(rx), .rx_tgl(rx_tgl)
  );
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  always @(posedge clock) begin
    alfsr <= lfsr_next(alfsr);
    adc_code <= alfsr[15:0];
    adc_neg <= alfsr[20] & alfsr[3];
    adc_ovr <= alfsr[25] & alfsr[9];
  end
  task automatic chk(input string nm, input logic [7:0] e, logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  always @(rx_tgl) begin
    if (exp_q.size() > 0) begin
      chk(name_q.pop_front(), exp_q.pop_front(), rx);
    end
  end
  task automatic pause(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic rd(input string nm, input logic [2:0] a, logic [7:0] e);
    name_q.push_back(nm);
    exp_q.push_back(e);
    host_u.frame_open();
    host_u.xbyte({5'h00, a}, 1'b0);
    host_u.xbyte(8'h00, 1'b1);
    host_u.frame_close();
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    host_u.frame_open();
    host_u.xbyte({1'b1, 4'h0, a}, 1'b0);
    host_u.xbyte(d, 1'b0);
    host_u.frame_close();
    pause(10);
  endtask
  task automatic test_done();
    $display("checked %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #(8 * 130000);
    fails++;
    $display("watchdog expired");
    test_done();
  end
  initial begin
    logic [7:0] v;
    logic [7:0] code[2];
    int ro[3];
    code = '{8'h84, 8'h8c};
    ro = '{1, 2, 7};
    pause(6);
    rst <= 1'b0;
    pause(4);
    for (int a = 0; a < 8; a++) begin
      rd("reset", a[2:0], (a == 3 || a == 4) ? 8'hff : 8'h00);
    end
    for (int a = 3; a < 7; a++) begin
      lfsr = lfsr_next(lfsr);
      v = lfsr[7:0];
      wr(a[2:0], v);
      rd("limit", a[2:0], v);
    end
    foreach (ro[i]) begin
      lfsr = lfsr_next(lfsr);
      wr(ro[i][2:0], lfsr[7:0]);
      rd("read only", ro[i][2:0], 8'h00);
    end
    $display("test registers done");
    wr(3'h0, 8'h80);
    #1 chk("bias on", 8'h01, {7'h00, exc});
    chk("ready idle", 8'h01, {7'h00, rdy_n});
    wr(3'h0, 8'h10);
    #1 chk("three wire", 8'h03, {6'h00, three, ~exc});
    wr(3'h0, 8'h40);
    #1 chk("cont bias", 8'h01, {7'h00, exc});
    rd("cont", 3'h0, 8'h40);
    wr(3'h0, 8'ha4);
    rd("both ignored", 3'h0, 8'h80);
    wr(3'h0, 8'ha0); // excitation already on
    rd("shot clear", 3'h0, 8'h80);
    $display("test modes done");
    pause(1);
    rst <= 1'b1;
    pause(3);
    rst <= 1'b0;
    pause(4);
    rd("second reset", 3'h0, 8'h00);
    ref_lo <= 1'b1;
    ret_lo <= 1'b1;
    wr(3'h0, 8'h80);
    wr(3'h0, 8'h88);
    pause(100);
    #1 chk("step one open", 8'h01, {7'h00, sw});
    rd("step one", 3'h0, 8'h88);
    wr(3'h0, 8'h8c);
    pause(100);
    #1 chk("step two shut", 8'h00, {7'h00, sw});
    rd("step two", 3'h0, 8'h80);
    rd("open faults", 3'h7, 8'h18);
    rd("summary", 3'h2, 8'h01);
    wr(3'h0, 8'h82);
    rd("cleared", 3'h7, 8'h00);
    rd("clear self", 3'h0, 8'h80);
    $display("test manual cycle done");
    ref_lo <= 1'b0;
    ret_lo <= 1'b0;
    ref_hi <= 1'b1;
    foreach (code[i]) begin
      wr(3'h0, 8'h82);
      wr(3'h0, code[i]);
      pause(3 * rtdc_pkg::SETTLE_CYC);
      rd("auto done", 3'h0, 8'h80);
      rd("ref high", 3'h7, 8'h20);
    end
    ref_hi <= 1'b0;
    wr(3'h0, 8'h82);
    $display("test auto cycle done");
    pin_f <= 1'b1;
    pause(10);
    rd("pin fault", 3'h7, 8'h04);
    wr(3'h0, 8'h82);
    rd("pin persists", 3'h7, 8'h04);
    pin_f <= 1'b0;
    pause(10);
    wr(3'h0, 8'h82);
    rd("pin cleared", 3'h7, 8'h00);
    $display("test pin fault done");
    test_done();
  end
endmodule
`default_nettype wire
